//--- design/self_program_pkg.sv
// constants shared by the self-programming controller and the cpu-side end
// assumes a single 25 MHz clock for both ends
package self_program_pkg;
    localparam int CLK_MHZ = 25;
    localparam logic [7:0] CSR_OFFSET = 8'h37;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam int BIT_STORE_ENABLE = 0;
    localparam int BIT_PAGE_ERASE = 1;
    localparam int BIT_PAGE_WRITE = 2;
    localparam int BIT_FUSE_LOCK_READ = 3;
    localparam int BIT_BUFFER_CLEAR = 4;
    localparam int BIT_SIGNATURE_READ = 5;
    localparam logic [7:0] CSR_WRITABLE = 8'h3F;
    localparam logic [7:0] CSR_READABLE = 8'h3F;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [15:0] INDEX_FUSE_LOW = 16'h0000;
    localparam logic [15:0] INDEX_LOCK = 16'h0001;
    localparam logic [15:0] INDEX_FUSE_EXTENDED = 16'h0002;
    localparam logic [15:0] INDEX_FUSE_HIGH = 16'h0003;
    localparam int WORD_BITS = 5;
    localparam int PAGE_WORDS = 32;
    localparam int PAGE_BITS = 7;
    // flash write time in microseconds, taken midway inside 3.7 ms .. 4.5 ms
    localparam int FLASH_MIN_US = 3700;
    localparam int FLASH_MAX_US = 4500;
    localparam int FLASH_CYCLES = (FLASH_MIN_US + FLASH_MAX_US) / 2 * CLK_MHZ;
    // host command port register map
    localparam logic [3:0] HOST_CMD = 4'h0;
    localparam logic [3:0] HOST_INDEX = 4'h1;
    localparam logic [3:0] HOST_DATA = 4'h2;
    localparam logic [3:0] HOST_STATUS = 4'h3;
    localparam logic [3:0] HOST_RESULT = 4'h4;
    localparam logic [3:0] HOST_ACTION = 4'h5;
    typedef enum logic [1:0] {ACT_CSR, ACT_LOAD, ACT_STORE} action_type;
endpackage : self_program_pkg

//--- design/self_program_if.sv
// cpu-to-controller link: csr access, load and store instruction strobes
// assumes both ends share one clock
`timescale 1ns/1ps
interface self_program_if (input wire logic CLK);
    logic csr_write;
    logic csr_read;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic load_valid;
    logic store_valid;
    logic [15:0] index;
    logic [15:0] store_data;
    logic load_special;
    logic [7:0] load_data;
    logic cpu_halt;
    modport device (input csr_write, csr_read, csr_wdata, load_valid, store_valid,
        index, store_data, output csr_rdata, load_special, load_data, cpu_halt);
    modport host (output csr_write, csr_read, csr_wdata, load_valid, store_valid,
        index, store_data, input csr_rdata, load_special, load_data, cpu_halt);
endinterface : self_program_if

//--- design/self_program_control.sv
// self-programming control and status register with arming windows and flash timer
// assumes the cpu end raises one-cycle load/store strobes and obeys cpu_halt
//
// What this block does
// [R01] armed fuse-lock read returns fuse/lock data
// [R02] read bits clear on load or timeout
// [R03] disarmed loads return program memory (the cpu end returns 00 instead)
// [R04] programmed bits read zero, unprogrammed one
// [R05] index 0001 selects lock bits
// [R06] index 0000 selects low fuse byte
// [R07] index 0003 selects high fuse byte
// [R08] index 0002 selects extended fuse byte
// [R09] armed signature read returns table byte
// [R10] bits 7:6 read zero, not writable
// [R11] buffer clear discards page buffer contents
// [R12] page write stores buffer to page
// [R13] page write bit clears on finish/timeout
// [R14] page erase clears addressed page
// [R15] page erase bit clears on finish/timeout
// [R16] cpu halted during erase or write
// [R17] plain store fills buffer word, lsb ignored
// [R18] store enable clears after store/timeout
// [R19] store enable stays set during operation
// [R20] flash operations timed 3.7 to 4.5 ms
// [R21] reset does not abort flash write
// [R22] eeprom write blocks programming and reads
// [R23] arming window counter clears stale commands
`timescale 1ns/1ps
module self_program_control
    import self_program_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    self_program_if.device LINK,
    input wire logic [7:0] FUSE_LOW,
    input wire logic [7:0] FUSE_HIGH,
    input wire logic [7:0] FUSE_EXTENDED,
    input wire logic [1:0] LOCK_BITS,
    input wire logic [7:0] SIGNATURE_DATA,
    input wire logic EEPROM_BUSY,
    output logic [5:0] SIGNATURE_INDEX,
    output logic FLASH_ERASE,
    output logic FLASH_WRITE,
    output logic [PAGE_BITS-1:0] FLASH_PAGE,
    output logic [16*PAGE_WORDS-1:0] FLASH_DATA
);
    typedef enum logic [1:0] {IDLE, ERASING, WRITING} flash_state_type;

    flash_state_type state;
    logic [5:0] csr;
    logic [2:0] window;
    logic [31:0] timer;
    logic [15:0] buffer [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buffer_loaded;
    logic armed_read;
    logic armed_sig;
    logic store_cmd;
    logic [7:0] special_data;

    // software reads of fuses/lock and any programming are blocked by eeprom activity
    assign armed_read = csr[BIT_STORE_ENABLE] && csr[BIT_FUSE_LOCK_READ]; // R01
    assign armed_sig = csr[BIT_STORE_ENABLE] && csr[BIT_SIGNATURE_READ]; // R09
    assign store_cmd = LINK.store_valid && csr[BIT_STORE_ENABLE] && state == IDLE
        && !EEPROM_BUSY && window > 3'h1; // R22 R12 R14 R17
    assign LINK.csr_rdata = {2'b00, csr}; // R10
    assign LINK.cpu_halt = (state != IDLE); // R16
    assign LINK.load_special = LINK.load_valid && (armed_read || armed_sig)
        && window >= STORE_WINDOW + 3'h2 - LOAD_WINDOW && !EEPROM_BUSY; // R01 R03
    assign LINK.load_data = special_data;
    assign SIGNATURE_INDEX = LINK.index[5:0];

    // fuse, lock or signature byte chosen by the index; bits are returned raw, 0 = programmed
    always_comb
    begin
        special_data = SIGNATURE_DATA; // R09
        if (armed_read)
        begin
            unique case (LINK.index)
                INDEX_FUSE_LOW: special_data = FUSE_LOW; // R06
                INDEX_LOCK: special_data = {6'h3F, LOCK_BITS}; // R05 R04
                INDEX_FUSE_EXTENDED: special_data = FUSE_EXTENDED; // R08
                INDEX_FUSE_HIGH: special_data = FUSE_HIGH; // R07
                default: special_data = 8'hFF;
            endcase
        end
    end

    // arming window: counts down the cycles left after the register write, store commands lapse when it reaches one, read commands at two
    always_ff @(posedge CLK)
    begin
        if (RST)
            window <= 3'h0;
        else if (CE)
        begin
            if (LINK.csr_write && state == IDLE && !EEPROM_BUSY)
                window <= STORE_WINDOW + 3'h1; // R23
            else if (window != 3'h0)
                window <= window - 3'h1; // R23
        end
    end

    // control register: writes, auto-clears and timeouts
    always_ff @(posedge CLK)
    begin
        if (RST && state == IDLE)
            csr <= CSR_RESET[5:0];
        else if (CE)
        begin
            if (state != IDLE)
            begin
                if (timer == 32'h0)
                    csr <= 6'h00; // R13 R15
                else
                    csr[BIT_STORE_ENABLE] <= 1'b1; // R19
            end
            else if (LINK.csr_write && !EEPROM_BUSY)
                csr <= LINK.csr_wdata[5:0] & CSR_WRITABLE[5:0]; // R10 R22
            else if (LINK.load_special)
                csr <= 6'h00; // R02
            else if (store_cmd && !(LINK.store_valid
                && (csr[BIT_PAGE_ERASE] || csr[BIT_PAGE_WRITE])))
                csr <= 6'h00; // R18
            else if (window == 3'h1)
                csr <= 6'h00; // R02 R13 R15 R18 R23
            else if (window == 3'h2 && (csr[BIT_FUSE_LOCK_READ] || csr[BIT_SIGNATURE_READ]))
                csr <= 6'h00; // R02
            else
                csr[BIT_BUFFER_CLEAR] <= 1'b0;
        end
    end

    // flash sequencer; a reset does not stop a running erase or write
    // busy test comes first so an unknown state at power-up falls through to reset
    always_ff @(posedge CLK)
    begin
        if (state != IDLE)
        begin
            if (CE)
            begin
                if (timer == 32'h0)
                    state <= IDLE; // R21
                else
                    timer <= timer - 32'h1; // R20
            end
        end
        else if (RST)
        begin
            state <= IDLE;
            timer <= 32'h0;
            FLASH_PAGE <= '0;
        end
        else if (CE)
        begin
            if (store_cmd && csr[BIT_PAGE_ERASE])
            begin
                state <= ERASING; // R14
                timer <= 32'(FLASH_CYCLES - 1); // R20
                FLASH_PAGE <= LINK.index[WORD_BITS+PAGE_BITS:WORD_BITS+1];
            end
            else if (store_cmd && csr[BIT_PAGE_WRITE])
            begin
                state <= WRITING; // R12
                timer <= 32'(FLASH_CYCLES - 1); // R20
                FLASH_PAGE <= LINK.index[WORD_BITS+PAGE_BITS:WORD_BITS+1];
            end
        end
    end

    // one-cycle flash strobes at the end of each timed operation
    always_ff @(posedge CLK)
    begin
        if (RST && state == IDLE)
        begin
            FLASH_ERASE <= 1'b0;
            FLASH_WRITE <= 1'b0;
        end
        else if (CE)
        begin
            FLASH_ERASE <= state == ERASING && timer == 32'h0; // R14
            FLASH_WRITE <= state == WRITING && timer == 32'h0; // R12
        end
    end

    // temporary page buffer, one write per word until cleared
    generate
        for (genvar w = 0; w < PAGE_WORDS; w++)
        begin : g_word
            always_ff @(posedge CLK)
            begin
                if (RST && state == IDLE)
                begin
                    buffer[w] <= 16'hFFFF;
                    buffer_loaded[w] <= 1'b0;
                end
                else if (CE)
                begin
                    if ((LINK.csr_write && LINK.csr_wdata[BIT_BUFFER_CLEAR] && state == IDLE)
                        || EEPROM_BUSY && buffer_loaded != '0
                        || FLASH_WRITE)
                    begin
                        buffer[w] <= 16'hFFFF; // R11
                        buffer_loaded[w] <= 1'b0; // R11
                    end
                    else if (store_cmd && csr[5:1] == 5'h00 && !buffer_loaded[w]
                        && LINK.index[WORD_BITS:1] == WORD_BITS'(w))
                    begin
                        buffer[w] <= LINK.store_data; // R17
                        buffer_loaded[w] <= 1'b1;
                    end
                end
            end
            assign FLASH_DATA[16*w +: 16] = buffer[w];
        end
    endgenerate
endmodule : self_program_control

//--- design/self_program_cpu.sv
// cpu-side end: turns register-port orders into csr writes and load/store strobes
// assumes software polls the status register before issuing an action
`timescale 1ns/1ps
module self_program_cpu
    import self_program_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    self_program_if.host LINK,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA
);
    logic [7:0] cmd;
    logic [15:0] index;
    logic [15:0] data;
    logic [7:0] result;
    logic [7:0] csr_seen;

    // order registers written by software
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cmd <= 8'h00;
            index <= 16'h0000;
            data <= 16'h0000;
        end
        else if (CE && WR)
        begin
            if (ADDR == HOST_CMD)
                cmd <= WDATA[7:0];
            if (ADDR == HOST_INDEX)
                index <= WDATA; // R05 R06 R07 R08
            if (ADDR == HOST_DATA)
                data <= WDATA;
        end
    end

    // an action write issues one csr write, load or store strobe the same cycle
    always_comb
    begin
        LINK.csr_write = CE && WR && ADDR == HOST_ACTION && WDATA[1:0] == 2'(ACT_CSR);
        LINK.load_valid = CE && WR && ADDR == HOST_ACTION && WDATA[1:0] == 2'(ACT_LOAD);
        LINK.store_valid = CE && WR && ADDR == HOST_ACTION
            && WDATA[1:0] == 2'(ACT_STORE) && !LINK.cpu_halt;
        LINK.csr_read = CE && RD && ADDR == HOST_STATUS;
        LINK.csr_wdata = cmd;
        LINK.index = index;
        LINK.store_data = data;
    end

    // captured load result and csr snapshot
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            result <= 8'h00;
            csr_seen <= 8'h00;
        end
        else if (CE)
        begin
            csr_seen <= LINK.csr_rdata;
            if (LINK.load_valid)
                result <= LINK.load_special ? LINK.load_data : 8'h00;
        end
    end

    // read data one cycle after the read strobe
    always_ff @(posedge CLK)
    begin
        if (RST)
            RDATA <= 16'h0000;
        else if (CE && RD)
        begin
            unique case (ADDR)
                HOST_CMD: RDATA <= {8'h00, cmd};
                HOST_INDEX: RDATA <= index;
                HOST_DATA: RDATA <= data;
                HOST_STATUS: RDATA <= {7'h00, LINK.cpu_halt, csr_seen};
                HOST_RESULT: RDATA <= {8'h00, result};
                default: RDATA <= 16'h0000;
            endcase
        end
    end
endmodule : self_program_cpu

//--- verification/self_program_monitor.sv
// link checker for the self-programming controller and its cpu end
// assumes it sits beside the link in the bench, one clock, RST sync high
`timescale 1ns/1ps
module self_program_monitor
    import self_program_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] csr_rdata,
    input wire logic load_valid,
    input wire logic store_valid,
    input wire logic load_special,
    input wire logic cpu_halt
);
    int unsigned halt_cnt;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // length of the running halt, kept through reset as the controller is
    always_ff @(posedge CLK)
    begin
        halt_cnt <= cpu_halt ? halt_cnt + 1 : 0;
    end
    AST_RESERVED_ZERO: assert property (csr_rdata[7:6] == 2'b00)
        else $error("reserved csr bits not zero");
    AST_PLAIN_LOAD: assert property (load_valid && !csr_rdata[0] |-> !load_special)
        else $error("unarmed load returned special data");
    AST_READ_DONE: assert property (load_valid && load_special |=> csr_rdata[5:0] == 6'h00)
        else $error("read bits not cleared after load");
    AST_READ_EXPIRE: assert property ($rose(csr_rdata[3]) |-> ##[1:6] !csr_rdata[3])
        else $error("fuse read bit outlived its window");
    AST_STORE_EXPIRE: assert property ($rose(csr_rdata[0]) && csr_rdata[2:1] == 2'b00
        |-> ##[1:6] !csr_rdata[0]) else $error("store enable outlived its window");
    AST_STORE_DONE: assert property (store_valid && csr_rdata[2:0] == 3'b001
        |=> !csr_rdata[0]) else $error("store enable kept after buffer store");
    AST_HALT_START: assert property (store_valid && csr_rdata[2:0] == 3'b011 |=> cpu_halt)
        else $error("erase store did not halt the cpu");
    AST_HALT_HOLD: assert property ($rose(cpu_halt) |-> (cpu_halt && csr_rdata[0]) [*8])
        else $error("halt or store enable dropped early");
    AST_HALT_TIME: assert property ($fell(cpu_halt) |-> halt_cnt >= FLASH_MIN_US * CLK_MHZ
        && halt_cnt <= FLASH_MAX_US * CLK_MHZ) else $error("flash operation time out of range");
endmodule : self_program_monitor

//--- verification/self_program_control_tb.sv
// bench joining the controller to its cpu end, driven through the host port
// assumes the host map and one-cycle strobes of the cpu end
`timescale 1ns/1ps
module self_program_control_tb
    import self_program_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic eeprom_busy = 1'b0;
    logic [7:0] fuse_low = 8'h62;
    logic [7:0] fuse_high = 8'hDF;
    logic [7:0] fuse_ext = 8'hFE;
    logic [1:0] lock_bits = 2'b10;
    logic [7:0] fuse_tab [4];
    logic [5:0] sig_index;
    logic flash_erase;
    logic flash_write;
    logic [PAGE_BITS-1:0] flash_page;
    logic [16*PAGE_WORDS-1:0] flash_data;
    logic [15:0] got;
    logic [7:0] cmds [5];
    int error_cnt = 0;
    int n_tests = 0;
    int cnt;
    // free-running system clock
    always #20 clk = ~clk;
    self_program_if self_program_if_inst (.CLK(clk));
    self_program_control self_program_control_inst (.CLK(clk), .RST(rst), .CE(ce),
        .LINK(self_program_if_inst), .FUSE_LOW(fuse_low), .FUSE_HIGH(fuse_high),
        .FUSE_EXTENDED(fuse_ext), .LOCK_BITS(lock_bits), .SIGNATURE_DATA({2'b10, sig_index}),
        .EEPROM_BUSY(eeprom_busy), .SIGNATURE_INDEX(sig_index), .FLASH_ERASE(flash_erase),
        .FLASH_WRITE(flash_write), .FLASH_PAGE(flash_page), .FLASH_DATA(flash_data));
    self_program_cpu self_program_cpu_inst (.CLK(clk), .RST(rst), .CE(ce),
        .LINK(self_program_if_inst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en),
        .RDATA(rdata));
    self_program_monitor self_program_monitor_inst (.CLK(clk), .RST(rst),
        .csr_rdata(self_program_if_inst.csr_rdata), .load_valid(self_program_if_inst.load_valid),
        .store_valid(self_program_if_inst.store_valid),
        .load_special(self_program_if_inst.load_special), .cpu_halt(self_program_if_inst.cpu_halt));
    // one host write cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // one host read cycle, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // index, command value, then the csr write itself
    task automatic arm(input logic [7:0] c, input logic [15:0] idx);
        wr(HOST_INDEX, idx);
        wr(HOST_CMD, {8'h00, c});
        wr(HOST_ACTION, {14'h0000, ACT_CSR});
    endtask : arm
    task automatic status(input logic [8:0] exp, input string what);
        rd(HOST_STATUS, got);
        chk(what, {7'h00, exp}, {7'h00, got[8:0]});
    endtask : status
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // main sequence
    initial
    begin
        fuse_tab = '{fuse_low, {6'h3F, lock_bits}, fuse_ext, fuse_high};
        cmds = '{8'h09, 8'h21, 8'h05, 8'h03, 8'h01};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        status(9'h000, "csr reset");
        for (int i = 0; i < 4; i++)
        begin
            arm(8'h09, i[15:0]);
            wr(HOST_ACTION, {14'h0000, ACT_LOAD});
            rd(HOST_RESULT, got);
            chk("fuse lock byte", {8'h00, fuse_tab[i]}, {8'h00, got[7:0]});
            status(9'h000, "csr after read");
        end
        arm(8'h21, 16'h0005);
        wr(HOST_ACTION, {14'h0000, ACT_LOAD});
        rd(HOST_RESULT, got);
        chk("signature byte", 16'h0085, {8'h00, got[7:0]});
        wr(HOST_ACTION, {14'h0000, ACT_LOAD});
        rd(HOST_RESULT, got);
        chk("plain load", 16'h0000, got);
        for (int i = 0; i < 5; i++)
        begin
            arm(cmds[i], 16'h0000);
            repeat (6) @(posedge clk);
            status(9'h000, "csr after window");
        end
        arm(8'hC1, 16'h0000);
        status(9'h001, "reserved bits");
        wr(HOST_DATA, 16'hA5C3);
        arm(8'h01, 16'h0007);
        wr(HOST_ACTION, {14'h0000, ACT_STORE});
        repeat (2) @(posedge clk);
        chk("buffer word", 16'hA5C3, flash_data[48+:16]);
        status(9'h000, "csr after store");
        arm(8'h11, 16'h0000);
        repeat (2) @(posedge clk);
        chk("cleared word", 16'hFFFF, flash_data[48+:16]);
        eeprom_busy <= 1'b1;
        arm(8'h09, 16'h0000);
        status(9'h000, "csr while eeprom busy");
        eeprom_busy <= 1'b0;
        arm(8'h03, 16'h0140);
        wr(HOST_ACTION, {14'h0000, ACT_STORE});
        status(9'h103, "halt during erase");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        status(9'h103, "halt across reset");
        for (cnt = 0; cnt < 105000 && flash_erase !== 1'b1; cnt++)
        begin
            @(posedge clk);
            #1;
        end
        if (cnt >= 105000)
        begin
            error_cnt++;
            $display("[FAIL] erase done expected 1 seen 0");
        end
        else
        begin
            chk("erase page", 16'h0005, {9'h000, flash_page});
            chk("write strobe", 16'h0000, {15'h0000, flash_write});
            status(9'h000, "csr after erase");
        end
        report_and_stop();
    end
endmodule : self_program_control_tb
